//--- logic/jbt_tap.sv
`timescale 1ns/10ps
`include "jbt_regs.svh"

module jbt_tap
	import jbt_pkg::*;
#(
	parameter int IR_LEN = `JBT_IR_LEN,
	parameter int BSR_LEN = `JBT_BSR_LEN,
	// Arbitrary identification values
	parameter logic [3:0] ID_REVISION = 4'h1,
	parameter logic [15:0] ID_DEVICE = 16'h1234,
	parameter logic [10:0] ID_VENDOR = 11'h055
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Test pins
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdo_oe,
	// I/O ring
	input wire logic [BSR_LEN-1:0] ring_pins_in,
	output logic [BSR_LEN-1:0] ring_bsr_out,
	output jbt_ring_t ring_ctrl,
	// Status
	output logic test_logic_reset
);

	if (IR_LEN != `JBT_IR_LEN) begin : g_ir_len_check
		$error("jbt_tap: IR_LEN must match the instruction codes");
	end

	// ****************************************
	// Functions
	// ****************************************
	// one path
	function automatic jbt_sel_t sel_of(input logic [IR_LEN-1:0] op);
		unique case (op)
			`JBT_OP_EXTEST,
			`JBT_OP_SAMPLE,
			`JBT_OP_HIGHZ: sel_of = SEL_BSR;
			`JBT_OP_IDCODE: sel_of = SEL_ID;
			default: sel_of = SEL_BYPASS;
		endcase
	endfunction

	function automatic jbt_state_t next_of(input jbt_state_t s, input logic m);
		unique case (s)
			ST_RESET: next_of = m ? ST_RESET : ST_IDLE;
			ST_IDLE: next_of = m ? ST_SEL_DR : ST_IDLE;
			ST_SEL_DR: next_of = m ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR: next_of = m ? ST_EXIT1_DR : ST_SHIFT_DR;
			ST_SHIFT_DR: next_of = m ? ST_EXIT1_DR : ST_SHIFT_DR;
			ST_EXIT1_DR: next_of = m ? ST_UPD_DR : ST_PAUSE_DR;
			ST_PAUSE_DR: next_of = m ? ST_EXIT2_DR : ST_PAUSE_DR;
			ST_EXIT2_DR: next_of = m ? ST_UPD_DR : ST_SHIFT_DR;
			ST_UPD_DR: next_of = m ? ST_SEL_DR : ST_IDLE;
			ST_SEL_IR: next_of = m ? ST_RESET : ST_CAP_IR;
			ST_CAP_IR: next_of = m ? ST_EXIT1_IR : ST_SHIFT_IR;
			ST_SHIFT_IR: next_of = m ? ST_EXIT1_IR : ST_SHIFT_IR;
			ST_EXIT1_IR: next_of = m ? ST_UPD_IR : ST_PAUSE_IR;
			ST_PAUSE_IR: next_of = m ? ST_EXIT2_IR : ST_PAUSE_IR;
			ST_EXIT2_IR: next_of = m ? ST_UPD_IR : ST_SHIFT_IR;
			ST_UPD_IR: next_of = m ? ST_SEL_DR : ST_IDLE;
			default: next_of = ST_RESET;
		endcase
	endfunction

	// ****************************************
	// Pin synchronisers and edge detection
	// ****************************************
	jbt_pins_t meta_q, sync_q;
	logic tck_old_q, tck_rise, tck_fall;

	// Two flops per pin, one more for the clock edge; reset high so a parked clock gives no false rise
	always_ff @(posedge core_clk) begin
		if (rst) begin
			meta_q <= '1;
			sync_q <= '1;
			tck_old_q <= 1'b1;
		end else begin
			meta_q <= '{tck: tck, tms: tms, tdi: tdi};
			sync_q <= meta_q;
			tck_old_q <= sync_q.tck;
		end
	end

	assign tck_rise = sync_q.tck & ~tck_old_q;
	assign tck_fall = ~sync_q.tck & tck_old_q;

	// ****************************************
	// Controller state
	// ****************************************
	jbt_state_t state_q, state_d;

	// Step on each test clock rising edge
	always_comb begin
		state_d = state_q;
		if (tck_rise) begin
			state_d = next_of(state_q, sync_q.tms);
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_q <= ST_RESET;
		end else begin
			state_q <= state_d;
		end
	end

	assign test_logic_reset = (state_q == ST_RESET);

	// ****************************************
	// Instruction register
	// ****************************************
	logic [IR_LEN-1:0] ir_shift_q, ir_shift_d;
	logic [IR_LEN-1:0] instr_q, instr_d;

	// Capture, shift and update of the instruction
	always_comb begin
		ir_shift_d = ir_shift_q;
		instr_d = instr_q;
		if (tck_rise) begin
			unique case (state_q)
				ST_CAP_IR: ir_shift_d = {instr_q[IR_LEN-1:2], `JBT_IR_CAPTURE};
				ST_SHIFT_IR: ir_shift_d = {sync_q.tdi, ir_shift_q[IR_LEN-1:1]};
				ST_UPD_IR: instr_d = ir_shift_q;
				ST_RESET: instr_d = `JBT_OP_IDCODE;
				default: ;
			endcase
		end
	end

	// Registers
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ir_shift_q <= `JBT_OP_IDCODE;
			instr_q <= `JBT_OP_IDCODE;
		end else begin
			ir_shift_q <= ir_shift_d;
			instr_q <= instr_d;
		end
	end

	// ****************************************
	// Bypass and identification registers
	// ****************************************
	jbt_sel_t sel;
	logic bypass_q, bypass_d;
	logic [`JBT_ID_LEN-1:0] id_q, id_d, id_word;

	assign sel = sel_of(instr_q);

	always_comb begin
		id_word = '0;
		id_word[`JBT_ID_REV_MSB:`JBT_ID_REV_LSB] = ID_REVISION;
		id_word[`JBT_ID_DEV_MSB:`JBT_ID_DEV_LSB] = ID_DEVICE;
		id_word[`JBT_ID_VEN_MSB:`JBT_ID_VEN_LSB] = ID_VENDOR;
		id_word[`JBT_ID_PRESENT_BIT] = 1'b1;
	end

	always_comb begin
		bypass_d = bypass_q;
		id_d = id_q;
		if (tck_rise) begin
			if (state_q == ST_CAP_DR) begin
				if (sel == SEL_BYPASS) begin
					bypass_d = `JBT_BYPASS_RESET;
				end
				if (sel == SEL_ID) begin
					id_d = id_word;
				end
			end else if (state_q == ST_SHIFT_DR) begin
				if (sel == SEL_BYPASS) begin
					bypass_d = sync_q.tdi;
				end
				if (sel == SEL_ID) begin
					id_d = {sync_q.tdi, id_q[`JBT_ID_LEN-1:1]};
				end
			end
		end
	end

	// Registers
	always_ff @(posedge core_clk) begin
		if (rst) begin
			bypass_q <= `JBT_BYPASS_RESET;
			id_q <= '0;
		end else begin
			bypass_q <= bypass_d;
			id_q <= id_d;
		end
	end

	// ****************************************
	// Boundary scan register
	// ****************************************
	logic bsr_capture, bsr_shift, bsr_update, bsr_lsb;

	assign bsr_capture = tck_rise & (state_q == ST_CAP_DR) & (sel == SEL_BSR);
	assign bsr_shift = tck_rise & (state_q == ST_SHIFT_DR) & (sel == SEL_BSR);
	assign bsr_update = tck_rise & (state_q == ST_UPD_DR) & (sel == SEL_BSR);

	jbt_bsr #(
		.LEN(BSR_LEN)
	) u_bsr (
		.core_clk(core_clk),
		.rst(rst),
		.capture_en(bsr_capture),
		.shift_en(bsr_shift),
		.update_en(bsr_update),
		.scan_in(sync_q.tdi),
		.pins_in(ring_pins_in),
		.scan_lsb(bsr_lsb),
		.update_q(ring_bsr_out)
	);

	// ****************************************
	// Ring control
	// ****************************************
	jbt_ring_t ring_d, ring_q;

	always_comb begin
		ring_d = '0;
		if (state_q != ST_RESET) begin
			ring_d.drive_from_bsr = (instr_q == `JBT_OP_EXTEST) | (instr_q == `JBT_OP_CLAMP);
			ring_d.force_hiz = (instr_q == `JBT_OP_HIGHZ);
		end
	end

	// Registers
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ring_q <= '0;
		end else begin
			ring_q <= ring_d;
		end
	end

	assign ring_ctrl = ring_q;

	// ****************************************
	// Serial output
	// ****************************************
	logic tdo_d, tdo_oe_d, tdo_q, tdo_oe_q;
	logic dr_lsb;

	always_comb begin
		unique case (sel)
			SEL_ID: dr_lsb = id_q[0];
			SEL_BSR: dr_lsb = bsr_lsb;
			default: dr_lsb = bypass_q;
		endcase
	end

	always_comb begin
		tdo_d = tdo_q;
		tdo_oe_d = tdo_oe_q;
		if (tck_fall) begin
			tdo_oe_d = (state_q == ST_SHIFT_IR) | (state_q == ST_SHIFT_DR);
			tdo_d = (state_q == ST_SHIFT_IR) ? ir_shift_q[0] : dr_lsb;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			tdo_q <= 1'b0;
			tdo_oe_q <= 1'b0;
		end else begin
			tdo_q <= tdo_d;
			tdo_oe_q <= tdo_oe_d;
		end
	end

	assign tdo = tdo_q;
	assign tdo_oe = tdo_oe_q;

endmodule // jbt_tap

//--- logic/jbt_regs.svh
`ifndef JBT_REGS_SVH
`define JBT_REGS_SVH

// ****************************************
// Register lengths
// ****************************************
`define JBT_IR_LEN 8
`define JBT_ID_LEN 32
`define JBT_BSR_LEN 113

// ****************************************
// Instruction codes
// ****************************************
`define JBT_OP_EXTEST 8'h00
`define JBT_OP_IDCODE 8'h21
`define JBT_OP_SAMPLE 8'h05
`define JBT_OP_HIGHZ 8'h03
`define JBT_OP_CLAMP 8'h07
`define JBT_OP_BYPASS 8'hFF

// ****************************************
// Fixed values and field positions
// ****************************************
`define JBT_IR_CAPTURE 2'h1
`define JBT_BYPASS_RESET 1'h0
`define JBT_ID_REV_MSB 31
`define JBT_ID_REV_LSB 28
`define JBT_ID_DEV_MSB 27
`define JBT_ID_DEV_LSB 12
`define JBT_ID_VEN_MSB 11
`define JBT_ID_VEN_LSB 1
`define JBT_ID_PRESENT_BIT 0

`endif

//--- logic/jbt_pkg.sv
package jbt_pkg;

	// ****************************************
	// Controller states, one-hot
	// ****************************************
	typedef enum logic [15:0] {
		ST_RESET = 16'h0001,
		ST_IDLE = 16'h0002,
		ST_SEL_DR = 16'h0004,
		ST_CAP_DR = 16'h0008,
		ST_SHIFT_DR = 16'h0010,
		ST_EXIT1_DR = 16'h0020,
		ST_PAUSE_DR = 16'h0040,
		ST_EXIT2_DR = 16'h0080,
		ST_UPD_DR = 16'h0100,
		ST_SEL_IR = 16'h0200,
		ST_CAP_IR = 16'h0400,
		ST_SHIFT_IR = 16'h0800,
		ST_EXIT1_IR = 16'h1000,
		ST_PAUSE_IR = 16'h2000,
		ST_EXIT2_IR = 16'h4000,
		ST_UPD_IR = 16'h8000
	} jbt_state_t;

	// ****************************************
	// Data register selection
	// ****************************************
	typedef enum logic [2:0] {
		SEL_BYPASS = 3'h1,
		SEL_ID = 3'h2,
		SEL_BSR = 3'h4
	} jbt_sel_t;

	// ****************************************
	// Control toward the I/O ring
	// ****************************************
	typedef struct packed {
		logic drive_from_bsr;
		logic force_hiz;
	} jbt_ring_t;

	// ****************************************
	// Test pins after synchronisation
	// ****************************************
	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
	} jbt_pins_t;

endpackage

//--- logic/jbt_bsr.sv
`timescale 1ns/10ps
`include "jbt_regs.svh"

module jbt_bsr
	import jbt_pkg::*;
#(
	parameter int LEN = `JBT_BSR_LEN
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Step controls from the controller
	input wire logic capture_en,
	input wire logic shift_en,
	input wire logic update_en,
	input wire logic scan_in,
	// I/O ring
	input wire logic [LEN-1:0] pins_in,
	output logic scan_lsb,
	output logic [LEN-1:0] update_q
);

	if (LEN < 2) begin : g_len_check
		$error("jbt_bsr: LEN must be at least 2");
	end

	// ****************************************
	// Shift stage and update stage
	// ****************************************
	logic [LEN-1:0] shift_q;
	logic [LEN-1:0] shift_d;
	logic [LEN-1:0] update_d;
	logic [LEN-1:0] pins_meta_q;
	logic [LEN-1:0] pins_sync_q;

	// Next values of both stages
	always_comb begin
		shift_d = shift_q;
		update_d = update_q;
		if (capture_en) begin
			shift_d = pins_sync_q;
		end else if (shift_en) begin
			shift_d = {scan_in, shift_q[LEN-1:1]};
		end
		if (update_en) begin
			update_d = shift_q;
		end
	end

	// Registers; ring pins pass two flops before capture
	always_ff @(posedge core_clk) begin
		if (rst) begin
			pins_meta_q <= '0;
			pins_sync_q <= '0;
			shift_q <= '0;
			update_q <= '0;
		end else begin
			pins_meta_q <= pins_in;
			pins_sync_q <= pins_meta_q;
			shift_q <= shift_d;
			update_q <= update_d;
		end
	end

	assign scan_lsb = shift_q[0];

endmodule // jbt_bsr

//--- verif/jbt_tap_properties.sv
`timescale 1ns/10ps
module jbt_tap_properties
	import jbt_pkg::*;
#(
	parameter int BSR_LEN = 113
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Test pins
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic tdo,
	input wire logic tdo_oe,
	// I/O ring
	input wire logic [BSR_LEN-1:0] ring_pins_in,
	input wire logic [BSR_LEN-1:0] ring_bsr_out,
	input wire jbt_ring_t ring_ctrl,
	// Status
	input wire logic test_logic_reset
);
	logic tck_q;
	logic [2:0] ones_q;
	logic [2:0] ones_d;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);

	// ****
	// Run of high mode-select samples
	// ****
	always_comb begin
		ones_d = ones_q;
		if (rst || (tck && !tck_q && !tms)) begin
			ones_d = 3'h0;
		end else if (tck && !tck_q && ones_q != 3'h5) begin
			ones_d = ones_q + 3'h1;
		end
	end
	always_ff @(posedge core_clk) begin
		tck_q <= tck;
		ones_q <= ones_d;
	end

	// ****
	// Properties
	// ****
	sequence s_fifth_one;
		ones_q == 3'h5 && $past(ones_q) == 3'h4;
	endsequence
	sequence s_tlr_soon;
		##[0:6] test_logic_reset;
	endsequence
	a_tdo_on_fall: assert property ($changed(tdo) |-> !tck && !$past(tck, 2))
		else $error("tdo moved while test clock high");
	a_oe_on_fall: assert property ($changed(tdo_oe) |-> !tck && !$past(tck, 2))
		else $error("output enable moved while test clock high");
	a_oe_off_tlr: assert property (test_logic_reset |-> !tdo_oe)
		else $error("tdo driven in reset state");
	a_reset_quiet: assert property (disable iff (1'b0) rst |=> test_logic_reset && !tdo_oe
		&& !tdo && !(|ring_bsr_out) && ring_ctrl == 2'h0)
		else $error("outputs not quiet after reset");
	a_five_ones: assert property (s_fifth_one |-> s_tlr_soon)
		else $error("five high samples did not reach reset state");
	a_tlr_leave: assert property ($fell(test_logic_reset) |-> !$past(tms, 2))
		else $error("reset state left with mode select high");
	a_ring_on_update: assert property ($changed(ring_bsr_out) |-> tck && $past(tck, 2))
		else $error("ring outputs moved off an update edge");
	a_ctrl_on_rise: assert property ($changed(ring_ctrl) |-> tck || test_logic_reset)
		else $error("ring control moved off a rising edge");
	a_ctrl_tlr_zero: assert property ($rose(test_logic_reset) |-> ##[0:20] ring_ctrl == 2'h0)
		else $error("ring control not cleared in reset state");
endmodule // jbt_tap_properties

bind jbt_tap jbt_tap_properties #(.BSR_LEN(BSR_LEN)) u_props (.core_clk(core_clk), .rst(rst), .tck(tck),
	.tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .ring_pins_in(ring_pins_in),
	.ring_bsr_out(ring_bsr_out), .ring_ctrl(ring_ctrl), .test_logic_reset(test_logic_reset));

//--- verif/jbt_jtag_host.sv
`timescale 1ns/10ps
module jbt_jtag_host (
	// Clock
	input wire logic core_clk,
	// Test pins
	input wire logic tdo,
	input wire logic tdo_oe,
	output logic tck,
	output logic tms,
	output logic tdi,
	// Observed serial bit
	output logic rx_valid,
	output logic rx_bit
);
	// Clock parked low, pulled-up lines high
	initial begin
		tck = 1'h0;
		tms = 1'h1;
		tdi = 1'h1;
		rx_valid = 1'h0;
		rx_bit = 1'h0;
	end

	// ****
	// One test clock period
	// ****
	// change while low
	task automatic step(input logic m, input logic d, input logic c);
		@(posedge core_clk);
		tck <= 1'h0;
		tms <= m;
		tdi <= d;
		repeat (4) @(posedge core_clk); // Four core clocks low, four high
		// Undriven line reads back inverted
		rx_bit <= tdo_oe ? tdo : ~tdo;
		rx_valid <= c;
		tck <= 1'h1;
		@(posedge core_clk);
		rx_valid <= 1'h0;
		repeat (2) @(posedge core_clk);
	endtask
endmodule // jbt_jtag_host

//--- verif/testbench.sv
`timescale 1ns/10ps
`include "jbt_regs.svh"
module testbench
	import jbt_pkg::*;
();
	logic core_clk, rst, tck, tms, tdi, tdo, tdo_oe, rx_valid, rx_bit, tlr, bsr;
	logic [112:0] pins, bsr_out;
	jbt_ring_t ctrl;
	logic [1:0] look;
	logic [31:0] lfsr_q = 32'h1235;
	logic [127:0] exp_q[$];
	logic [127:0] d, p;
	logic [7:0] op, cur;
	int len, miscompares, check_count;
	logic [7:0] ops [7] = '{`JBT_OP_EXTEST, `JBT_OP_IDCODE, `JBT_OP_SAMPLE, `JBT_OP_HIGHZ,
		`JBT_OP_CLAMP, `JBT_OP_BYPASS, 8'hC0};
	localparam logic [31:0] ID_WORD = {4'h6, 16'hC3A5, 11'h1D2, 1'h1}; // Arbitrary values

	initial begin
		core_clk = 1'h0;
		forever #12.5 core_clk = ~core_clk;
	end

	jbt_tap #(.ID_REVISION(ID_WORD[31:28]), .ID_DEVICE(ID_WORD[27:12]), .ID_VENDOR(ID_WORD[11:1])) uut (
		.core_clk(core_clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
		.ring_pins_in(pins), .ring_bsr_out(bsr_out), .ring_ctrl(ctrl), .test_logic_reset(tlr));
	jbt_jtag_host host (.core_clk(core_clk), .tdo(tdo), .tdo_oe(tdo_oe), .tck(tck), .tms(tms),
		.tdi(tdi), .rx_valid(rx_valid), .rx_bit(rx_bit));

	// ****
	// Helpers
	// ****
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic rnd(output logic [127:0] r);
		for (int i = 0; i < 4; i++) begin
			lfsr_q = lfsr(lfsr_q);
			r = {r[95:0], lfsr_q};
		end
	endtask
	task automatic check(input logic [127:0] seen, input logic [127:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic test_done();
		$display("comparisons %0d, mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic note(input logic [127:0] e, input logic [1:0] w);
		exp_q.push_back(e);
		look <= w;
		@(posedge core_clk);
		look <= 2'h0;
	endtask
	task automatic scan(input logic ir, input int n, input logic [127:0] din, input logic [127:0] cap,
		input int len);
		host.step(1'h1, 1'h1, 1'h0);
		if (ir) host.step(1'h1, 1'h1, 1'h0);
		host.step(1'h0, 1'h1, 1'h0);
		host.step(1'h0, 1'h1, 1'h0);
		for (int i = 0; i < n; i++) begin
			exp_q.push_back({127'h0, i < len ? cap[i] : din[i - len]});
			host.step(i == n - 1 || i == 0, din[i], 1'h1);
			if (i == 0 && n > 1) begin
				host.step(1'h0, 1'h1, 1'h0);
				host.step(1'h1, 1'h1, 1'h0);
				host.step(1'h0, 1'h1, 1'h0);
			end
		end
		host.step(1'h1, 1'h1, 1'h0);
		host.step(1'h0, 1'h1, 1'h0);
		repeat (2) @(posedge core_clk);
	endtask

	// ****
	// Result monitor
	// ****
	always @(posedge core_clk) begin
		if (rx_valid) check({127'h0, rx_bit}, exp_q.pop_front());
		if (look == 2'h1) check({15'h0, bsr_out}, exp_q.pop_front());
		if (look == 2'h2) check({126'h0, ctrl}, exp_q.pop_front());
		if (look == 2'h3) check({127'h0, tlr}, exp_q.pop_front());
	end

	// ****
	// Main sequence
	// ****
	initial begin
		rst = 1'h1;
		pins = 113'h0;
		look = 2'h0;
		cur = `JBT_OP_IDCODE;
		repeat (2) @(posedge core_clk);
		rst <= 1'h0;
		host.step(1'h0, 1'h1, 1'h0);
		rnd(d);
		scan(1'h0, 40, d, {96'h0, ID_WORD}, 32);
		for (int k = 0; k < 7; k++) begin
			rnd(d);
			op = (k == 6) ? {4'hC, d[3:0]} : ops[k];
			scan(1'h1, 8, {120'h0, op}, {120'h0, cur[7:2], 2'h1}, 8);
			cur = op;
			note({126'h0, op == `JBT_OP_EXTEST || op == `JBT_OP_CLAMP, op == `JBT_OP_HIGHZ}, 2'h2);
			bsr = op == `JBT_OP_EXTEST || op == `JBT_OP_SAMPLE || op == `JBT_OP_HIGHZ;
			len = bsr ? 113 : (op == `JBT_OP_IDCODE) ? 32 : 1;
			rnd(p);
			pins <= p[112:0];
			rnd(d);
			scan(1'h0, len + 8, d, bsr ? {15'h0, p[112:0]} : (op == `JBT_OP_IDCODE) ? {96'h0, ID_WORD} : 128'h0,
				len);
			if (bsr) note({15'h0, d[120:8]}, 2'h1);
		end
		host.step(1'h1, 1'h1, 1'h0);
		host.step(1'h0, 1'h1, 1'h0);
		host.step(1'h0, 1'h1, 1'h0);
		repeat (5) host.step(1'h1, 1'h1, 1'h0);
		host.step(1'h0, 1'h1, 1'h0);
		rnd(d);
		scan(1'h0, 33, d, {96'h0, ID_WORD}, 32);
		rst <= 1'h1;
		repeat (2) @(posedge core_clk);
		rst <= 1'h0;
		repeat (4) @(posedge core_clk);
		note({127'h0, 1'h1}, 2'h3);
		@(posedge core_clk);
		test_done();
	end

	// Hang guard
	initial begin
		repeat (30000) @(posedge core_clk);
		miscompares++;
		test_done();
	end
endmodule // testbench
